// >>> lbhp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lbhp_host_model
	import lbhp_pkg::*;
(
	// Clock and device answers
	input  wire logic              clock_i,
	input  wire logic              ready_low_i,
	input  wire logic              dev_oe_i,
	input  wire logic [DATA_W-1:0] bus_i,
	input  wire logic              rom_sel_n_i,
	// Host drive
	output lbhp_pins_type          pins_o,
	output logic [DATA_W-1:0]      host_d_o,
	output logic                   host_oe_o
);
	initial begin
		pins_o = PINS_IDLE;
		host_d_o = '0;
		host_oe_o = 1'b0;
	end

	// The cycle is held whole until ready is released and, on a read, the device drives data or, on a write, six cycles pass; it gives up after 40 cycles.
	task automatic io_cycle(input logic wr, input logic qual,
		input logic [ADDR_W-1:0] a, input logic ube_n,
		input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
		output logic st, output logic ok);
		st = 1'b0;
		ok = 1'b0;
		@(negedge clock_i);
		pins_o.addr = a;
		pins_o.qual = qual;
		pins_o.ube_n = ube_n;
		pins_o.rd_n = wr;
		pins_o.wr_n = !wr;
		host_d_o = wd;
		host_oe_o = wr;
		for (int n = 0; n < 40 && !ok; n++) begin
			@(negedge clock_i);
			st |= ready_low_i;
			ok = !ready_low_i && (wr ? n >= 5 : dev_oe_i);
		end
		rd = bus_i;
		pins_o = PINS_IDLE;
		host_oe_o = 1'b0;
		repeat (4) @(negedge clock_i);
	endtask : io_cycle

	task automatic mem_rd(input logic [ADDR_W-1:0] a, output logic sel_n);
		@(negedge clock_i);
		pins_o.addr = a;
		pins_o.memr_n = 1'b0;
		repeat (5) @(negedge clock_i);
		sel_n = rom_sel_n_i;
		pins_o = PINS_IDLE;
		repeat (4) @(negedge clock_i);
	endtask : mem_rd
endmodule : lbhp_host_model
`default_nettype wire

// >>> lbhp_pkg.sv
// Behaviour
// - Boot ROM strap is caught when the filtered reset releases; it picks pin use.
// - Strap open: pin becomes ROM select, low on memory read in ROM window.
// - I/O decode only while the address qualifier is low; host holds it low.
// - Upper byte enable low marks data bits 15 to 8 valid this cycle.
// - Open-drain ready pulled low stretches a host cycle until released.
// - A 16-bit two-way data bus carries register reads and writes.
// - Reset pin is active high and taken only after 100 ns asserted.
// - Pending interrupts are shown by driving the interrupt output high.
// - In 16-bit mode wide ack goes low on qualified A15..A4 base match.
// - A read is recognised only while the I/O read strobe is low.
// - A write is recognised only while the I/O write strobe is low.
// - Board select LED lights on decoded I/O access and is stretched.
`default_nettype none
package lbhp_pkg;
	localparam int ADDR_W       = 20;
	localparam int DATA_W       = 16;
	localparam int CLK_MHZ      = 40;
	localparam int RST_MIN_NS   = 100;
	localparam int RST_FILT_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int LED_HOLD_US  = 20000;
	localparam int LED_HOLD_CYC = LED_HOLD_US * CLK_MHZ;
	localparam int IO_MATCH_LSB = 4;
	localparam int IO_MATCH_MSB = 15;
	localparam int ROM_MATCH_LSB = 14;
	localparam logic [5:0] ROM_BASE_DEF = 6'h30;
	localparam logic STRAP_RST  = 1'b1;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              qual;
		logic              ube_n;
		logic              rd_n;
		logic              wr_n;
		logic              memr_n;
	} lbhp_pins_type;

	localparam lbhp_pins_type PINS_IDLE = '1;

	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [3:0]        offset;
		logic [1:0]        be;
		logic [DATA_W-1:0] wdata;
	} lbhp_req_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RD_WAIT,
		ST_RD_HOLD,
		ST_WR_HOLD
	} lbhp_state_type;
endpackage : lbhp_pkg
`default_nettype wire

// >>> lbhp_port.sv
`timescale 1ns/1ps
`default_nettype none
module lbhp_port
	import lbhp_pkg::*;
#(
	parameter int         LED_CYC  = LED_HOLD_CYC,
	parameter logic [5:0] ROM_BASE = ROM_BASE_DEF
) (
	// Clock and power-on reset
	input  wire logic                 clock_i,
	input  wire logic                 rst_n_i,
	// Host bus pins
	input  wire logic [ADDR_W-1:0]    addr_i,
	input  wire logic                 address_qualifier_i,
	input  wire logic                 upper_byte_enable_n_i,
	input  wire logic                 io_read_strobe_n_i,
	input  wire logic                 io_write_strobe_n_i,
	input  wire logic                 mem_read_strobe_n_i,
	input  wire logic                 reset_pin_i,
	input  wire logic [DATA_W-1:0]    data_i,
	output logic      [DATA_W-1:0]    data_o,
	output logic                      data_oe_o,
	// Strap and ROM select pin
	input  wire logic                 boot_rom_select_strap_i,
	output logic                      boot_rom_select_strap_o,
	output logic                      boot_rom_select_strap_oe_o,
	// Open-drain and plain outputs
	output logic                      cycle_ready_o,
	output logic                      cycle_ready_oe_o,
	output logic                      wide_io_ack_n_o,
	output logic                      wide_io_ack_oe_o,
	output logic                      host_irq_o,
	output logic                      board_select_led_n_o,
	output logic                      board_select_led_oe_o,
	// Core side
	input  wire logic [11:0]          io_base_i,
	input  wire logic                 wide_mode_i,
	input  wire logic                 core_irq_i,
	input  wire logic [DATA_W-1:0]    core_rdata_i,
	input  wire logic                 core_rvalid_i,
	output lbhp_req_type              req_o,
	output logic                      dev_reset_o,
	output logic                      strap_mode_o
);
	lbhp_pins_type      pins_meta_q;
	lbhp_pins_type      pins_q;
	logic [DATA_W-1:0]  data_meta_q;
	logic [DATA_W-1:0]  data_q;
	logic               rst_meta_q;
	logic               rst_sync_q;
	logic               strap_meta_q;
	logic               strap_sync_q;
	logic [2:0]         rst_cnt_q;
	logic               dev_rst_q;
	logic               strap_mode_q;
	logic               rom_cs_q;
	lbhp_state_type     state_q;
	lbhp_req_type       req_q;
	logic [DATA_W-1:0]  rdata_q;
	logic               ack_q;
	logic               irq_q;
	logic [31:0]        led_cnt_q;
	logic               io_hit;
	logic               rd_hit;
	logic               wr_hit;
	logic               rom_hit;

	function automatic logic addr_match(input lbhp_pins_type p,
		input logic [11:0] base);
		addr_match = !p.qual &&
			p.addr[IO_MATCH_MSB:IO_MATCH_LSB] == base;
	endfunction : addr_match

	// Every pin passes two flip-flops before any logic looks at it.
	// The reset pin reads as asserted until the chain has seen it, so
	// the strap is caught from the real pin and not from a reset value.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pins_meta_q  <= PINS_IDLE;
			pins_q       <= PINS_IDLE;
			data_meta_q  <= '0;
			data_q       <= '0;
			rst_meta_q   <= 1'b1;
			rst_sync_q   <= 1'b1;
			strap_meta_q <= STRAP_RST;
			strap_sync_q <= STRAP_RST;
		end else begin
			pins_meta_q  <= '{addr: addr_i, qual: address_qualifier_i,
				ube_n: upper_byte_enable_n_i, rd_n: io_read_strobe_n_i,
				wr_n: io_write_strobe_n_i, memr_n: mem_read_strobe_n_i};
			pins_q       <= pins_meta_q;
			data_meta_q  <= data_i;
			data_q       <= data_meta_q;
			rst_meta_q   <= reset_pin_i;
			rst_sync_q   <= rst_meta_q;
			strap_meta_q <= boot_rom_select_strap_i;
			strap_sync_q <= strap_meta_q;
		end
	end

	// The count restarts on any drop, so a short spike never resets the core.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_cnt_q <= '0;
			dev_rst_q <= 1'b1;
		end else if (!rst_sync_q) begin
			rst_cnt_q <= '0;
			dev_rst_q <= 1'b0;
		end else if (rst_cnt_q == 3'(RST_FILT_CYC - 1)) begin
			dev_rst_q <= 1'b1;
		end else begin
			rst_cnt_q <= rst_cnt_q + 3'h1;
		end
	end

	// Strap is read while the pin is still released, on the release cycle.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_mode_q <= STRAP_RST;
		end else if (dev_rst_q && !rst_sync_q) begin
			strap_mode_q <= strap_sync_q;
		end
	end

	assign io_hit  = addr_match(pins_q, io_base_i) && !dev_rst_q;
	assign rd_hit  = io_hit && !pins_q.rd_n;
	assign wr_hit  = io_hit && !pins_q.wr_n;
	assign rom_hit = !pins_q.memr_n && !dev_rst_q &&
		pins_q.addr[ADDR_W-1:ROM_MATCH_LSB] == ROM_BASE;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rom_cs_q <= 1'b0;
		end else begin
			rom_cs_q <= strap_mode_q && rom_hit;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ack_q <= wide_mode_i && io_hit;
			irq_q <= core_irq_i && !dev_rst_q;
		end
	end

	// Writes are posted when the strobe rises, with the last data seen.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			req_q   <= '0;
			rdata_q <= '0;
		end else begin
			req_q.rd <= 1'b0;
			req_q.wr <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					req_q.offset <= pins_q.addr[3:0];
					req_q.be     <= {!pins_q.ube_n, !pins_q.addr[0]};
					if (rd_hit) begin
						req_q.rd <= 1'b1;
						state_q  <= ST_RD_WAIT;
					end else if (wr_hit) begin
						req_q.wdata <= data_q;
						state_q     <= ST_WR_HOLD;
					end
				end
				ST_RD_WAIT: begin
					if (core_rvalid_i) begin
						rdata_q <= core_rdata_i;
						state_q <= ST_RD_HOLD;
					end
				end
				ST_RD_HOLD: begin
					if (!rd_hit) begin
						state_q <= ST_IDLE;
					end
				end
				ST_WR_HOLD: begin
					if (wr_hit) begin
						req_q.wdata <= data_q;
						req_q.be[1] <= !pins_q.ube_n;
					end else begin
						req_q.wr <= 1'b1;
						state_q  <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Stretching keeps a single short access visible to the eye.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			led_cnt_q <= '0;
		end else if (rd_hit || wr_hit) begin
			led_cnt_q <= 32'(LED_CYC);
		end else if (led_cnt_q != '0) begin
			led_cnt_q <= led_cnt_q - 32'h1;
		end
	end

	assign data_o                     = rdata_q;
	assign data_oe_o                  = rd_hit && state_q == ST_RD_HOLD;
	assign cycle_ready_o              = 1'b0;
	assign cycle_ready_oe_o           = state_q == ST_RD_WAIT;
	assign wide_io_ack_n_o            = 1'b0;
	assign wide_io_ack_oe_o           = ack_q;
	assign host_irq_o                 = irq_q;
	assign board_select_led_n_o       = 1'b0;
	assign board_select_led_oe_o      = led_cnt_q != '0;
	assign boot_rom_select_strap_o    = !rom_cs_q;
	assign boot_rom_select_strap_oe_o = strap_mode_q && !dev_rst_q;
	assign req_o                      = req_q;
	assign dev_reset_o                = dev_rst_q;
	assign strap_mode_o               = strap_mode_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_rd_start;
		state_q == ST_IDLE && rd_hit;
	endsequence
	sequence s_rd_done;
		state_q == ST_RD_WAIT && core_rvalid_i;
	endsequence
	sequence s_wr_end;
		state_q == ST_WR_HOLD && !wr_hit;
	endsequence
	sequence s_wr_hold;
		state_q == ST_WR_HOLD && wr_hit;
	endsequence

	AST_RST_FILTER: assert property (rst_sync_q [*4] |=> dev_rst_q)
		else $error("reset pin held four cycles but core not reset");
	AST_RST_GLITCH: assert property (
		$rose(rst_sync_q) && !dev_rst_q |-> !dev_rst_q [*4])
		else $error("core reset taken before filter time");
	AST_STRAP_HOLD: assert property (
		!dev_rst_q && $past(!dev_rst_q) |-> $stable(strap_mode_q))
		else $error("strap mode changed outside reset release");
	AST_ROM_CS: assert property (
		(!dev_rst_q && strap_mode_q && rom_hit) ##1 !dev_rst_q
		|-> boot_rom_select_strap_oe_o && !boot_rom_select_strap_o)
		else $error("ROM select not asserted on ROM read");
	AST_QUAL_GATE: assert property (
		state_q == ST_IDLE && pins_q.qual
		|=> state_q == ST_IDLE && !req_q.rd && !req_q.wr)
		else $error("access decoded with qualifier high");
	AST_RD_STALL: assert property (
		s_rd_start |=> req_q.rd && cycle_ready_oe_o)
		else $error("read start did not request and stall");
	AST_RD_RELEASE: assert property (
		s_rd_done |=> !cycle_ready_oe_o && data_o == $past(core_rdata_i))
		else $error("ready not released with read data");
	AST_DATA_OE: assert property (
		data_oe_o |-> !pins_q.rd_n && !pins_q.qual && !cycle_ready_oe_o)
		else $error("data bus driven outside a decoded read");
	AST_WR_POST: assert property (
		s_wr_end |=> req_q.wr && req_q.wdata == $past(req_q.wdata))
		else $error("write not posted at strobe release");
	AST_WIDE_ACK: assert property (
		!wide_mode_i || !io_hit |=> !wide_io_ack_oe_o)
		else $error("wide ack driven without mode and match");
	AST_IRQ: assert property (
		core_irq_i && !dev_rst_q |=> host_irq_o)
		else $error("interrupt not forwarded");
	AST_LED: assert property (
		rd_hit || wr_hit |=> board_select_led_oe_o [*2])
		else $error("board select indicator not lit on access");
	AST_WR_START: assert property (
		state_q == ST_IDLE && !rd_hit && wr_hit
		|=> state_q == ST_WR_HOLD && !req_q.wr)
		else $error("write posted before strobe release");
	AST_RD_LANES: assert property (
		state_q == ST_IDLE && rd_hit && !pins_q.ube_n |=> req_q.be[1])
		else $error("upper lane not marked on wide read");
	AST_WR_DATA: assert property (
		s_wr_hold |=> req_q.wdata == $past(data_q))
		else $error("write data not taken while strobe low");
	AST_ACK_ON: assert property (
		wide_mode_i && io_hit |=> wide_io_ack_oe_o)
		else $error("wide ack missing on decoded access");
	AST_IRQ_OFF: assert property (
		!core_irq_i || dev_rst_q |=> !host_irq_o)
		else $error("interrupt driven with nothing pending");
	AST_ROM_IDLE: assert property (
		!rom_hit |=> boot_rom_select_strap_o)
		else $error("ROM select active outside a ROM read");
	AST_STRAP_FLOAT: assert property (
		dev_rst_q |-> !boot_rom_select_strap_oe_o)
		else $error("strap pin driven during reset");
	AST_RST_RELEASE: assert property (
		!rst_sync_q |=> !dev_rst_q)
		else $error("core reset held after pin release");
	AST_DATA_REL: assert property (
		!rd_hit |-> !data_oe_o)
		else $error("data bus driven without a decoded read");
	AST_LED_OFF: assert property (
		led_cnt_q == 32'h0 && !rd_hit && !wr_hit
		|=> !board_select_led_oe_o)
		else $error("board select indicator lit without access");
endmodule : lbhp_port
`default_nettype wire

// >>> local_bus_host_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module local_bus_host_port_tb_top;
	import lbhp_pkg::*;
	localparam logic [11:0] BASE = 12'h030;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic rst_pin = 1'b0;
	logic irq_in = 1'b0;
	logic wide = 1'b1;
	logic rvalid = 1'b0;
	logic [15:0] bus, dev_d, host_d;
	logic oe, host_oe, sel_o, sel_oe, sel_pin, rdy_o, rdy_oe, ack_o, ack_oe;
	logic irq, led_o, led_oe, dev_rst, strap;
	lbhp_pins_type pins;
	lbhp_req_type req, last;
	int n_rd, n_wr, rd_wait, n_errors, num_checks;
	logic ack_seen;

	always #12.5 clock_i = ~clock_i;
	// Weak pull-ups hold lines that nobody drives.
	assign bus = oe ? dev_d : (host_oe ? host_d : 16'hffff);
	assign sel_pin = sel_oe ? sel_o : 1'b1;

	lbhp_port #(.LED_CYC(16)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.addr_i(pins.addr), .address_qualifier_i(pins.qual),
		.upper_byte_enable_n_i(pins.ube_n), .io_read_strobe_n_i(pins.rd_n),
		.io_write_strobe_n_i(pins.wr_n), .mem_read_strobe_n_i(pins.memr_n),
		.reset_pin_i(rst_pin), .data_i(bus), .data_o(dev_d), .data_oe_o(oe),
		.boot_rom_select_strap_i(sel_pin), .boot_rom_select_strap_o(sel_o),
		.boot_rom_select_strap_oe_o(sel_oe), .cycle_ready_o(rdy_o),
		.cycle_ready_oe_o(rdy_oe), .wide_io_ack_n_o(ack_o),
		.wide_io_ack_oe_o(ack_oe), .host_irq_o(irq),
		.board_select_led_n_o(led_o), .board_select_led_oe_o(led_oe),
		.io_base_i(BASE), .wide_mode_i(wide), .core_irq_i(irq_in),
		.core_rdata_i(16'hc35a), .core_rvalid_i(rvalid), .req_o(req),
		.dev_reset_o(dev_rst), .strap_mode_o(strap));

	lbhp_host_model host (.clock_i(clock_i), .ready_low_i(rdy_oe),
		.dev_oe_i(oe), .bus_i(bus), .rom_sel_n_i(sel_pin), .pins_o(pins),
		.host_d_o(host_d), .host_oe_o(host_oe));

	// Outputs are watched at the falling edge, where they have settled.
	always @(negedge clock_i) begin
		if (req.rd === 1'b1 || req.wr === 1'b1) last = req;
		if (req.rd === 1'b1) n_rd++;
		if (req.wr === 1'b1) n_wr++;
		if (ack_oe === 1'b1) ack_seen = 1'b1;
	end

	// Core answers a read a few cycles late so that ready must stretch.
	always @(negedge clock_i) begin
		rvalid <= (rd_wait == 1);
		if (req.rd === 1'b1) rd_wait <= 4;
		else if (rd_wait > 0) rd_wait <= rd_wait - 1;
	end

	task automatic chk(input logic c, input string m);
		num_checks++;
		if (c !== 1'b1) begin
			n_errors++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic t_read();
		logic [15:0] d;
		logic st, ok;
		int r0;
		r0 = n_rd;
		ack_seen = 1'b0;
		host.io_cycle(1'b0, 1'b0, {4'h0, BASE, 4'h6}, 1'b0, '0, d, st, ok);
		chk(ok === 1'b1 && d === 16'hc35a, "read data");
		chk(st === 1'b1, "ready stretch");
		chk(n_rd == r0 + 1 && last.offset === 4'h6, "read req");
		chk(last.be === 2'b11, "read lanes");
		chk(oe === 1'b0, "bus release");
		chk(ack_seen === 1'b1, "wide ack");
		chk(led_oe === 1'b1, "led on");
		chk(rdy_o === 1'b0 && ack_o === 1'b0 && led_o === 1'b0,
			"open-drain low");
		$display("read test done");
	endtask : t_read

	task automatic t_write();
		logic [15:0] d;
		logic st, ok;
		int w0;
		w0 = n_wr;
		wide = 1'b0;
		ack_seen = 1'b0;
		host.io_cycle(1'b1, 1'b0, {4'h0, BASE, 4'hb}, 1'b0, 16'ha55a, d, st,
			ok);
		wide = 1'b1;
		chk(ok === 1'b1 && n_wr == w0 + 1, "write posted");
		chk(last.wdata === 16'ha55a, "write data");
		chk(last.offset === 4'hb && last.be === 2'b10, "wr lanes");
		chk(ack_seen === 1'b0, "narrow mode ack");
		$display("write test done");
	endtask : t_write

	task automatic t_refuse();
		logic [15:0] d;
		logic st, ok1, ok2;
		int r0;
		repeat (24) @(negedge clock_i);
		chk(led_oe === 1'b0, "led end");
		r0 = n_rd;
		ack_seen = 1'b0;
		host.io_cycle(1'b0, 1'b1, {4'h0, BASE, 4'h2}, 1'b1, '0, d, st, ok1);
		host.io_cycle(1'b0, 1'b0, {4'h0, ~BASE, 4'h2}, 1'b1, '0, d, st, ok2);
		chk(ok1 === 1'b0 && ok2 === 1'b0 && n_rd == r0, "refuse");
		chk(ack_seen === 1'b0 && led_oe === 1'b0, "no ack");
		$display("refuse test done");
	endtask : t_refuse

	task automatic t_misc();
		logic s1, s2;
		host.mem_rd({6'h30, 14'h0123}, s1);
		host.mem_rd({6'h31, 14'h0123}, s2);
		chk(s1 === 1'b0 && s2 === 1'b1, "rom select");
		irq_in = 1'b1;
		repeat (2) @(negedge clock_i);
		chk(irq === 1'b1, "irq high");
		irq_in = 1'b0;
		repeat (2) @(negedge clock_i);
		chk(irq === 1'b0, "irq low");
		s1 = 1'b0;
		rst_pin = 1'b1;
		repeat (2) @(negedge clock_i);
		rst_pin = 1'b0;
		repeat (8) begin
			@(negedge clock_i);
			s1 |= dev_rst;
		end
		chk(s1 === 1'b0, "glitch ignored");
		rst_pin = 1'b1;
		repeat (10) @(negedge clock_i);
		chk(dev_rst === 1'b1, "reset taken");
		rst_pin = 1'b0;
		repeat (8) @(negedge clock_i);
		chk(dev_rst === 1'b0 && strap === 1'b1, "strap again");
		$display("misc test done");
	endtask : t_misc

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	// Cuts a hang short well inside the cycle budget.
	initial begin
		#1ms;
		n_errors++;
		wrap_up();
	end

	initial begin
		repeat (12) @(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (10) @(negedge clock_i);
		chk(dev_rst === 1'b0 && strap === 1'b1, "strap capture");
		t_read();
		t_write();
		t_refuse();
		t_misc();
		wrap_up();
	end
endmodule : local_bus_host_port_tb_top
`default_nettype wire
